// [hdl/wdit_pkg.sv]
// Constants shared by the watchdog / interval timer block
package wdit_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned SYS_CLK_NS        = 20;
  localparam int unsigned RST_PULSE_NS      = 1000;
  localparam int unsigned RST_PULSE_CYCLES  = (RST_PULSE_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam int unsigned RC_TICK_NS        = 1000000;
  localparam int unsigned RC_TICK_CYCLES    = RC_TICK_NS / SYS_CLK_NS;
  localparam int unsigned OSC_STABLE_NS     = 2000000;
  localparam int unsigned OSC_STABLE_CYCLES = (OSC_STABLE_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;

  // ----------------------------------------------------------------
  // Timeout selection: 16 ms doubled per step, 2.048 s at the top
  // ----------------------------------------------------------------
  localparam int unsigned TIMEOUT_MIN_MS  = 16;
  localparam int unsigned CNT_W           = 12;
  localparam int unsigned HOLD_W          = 24;
  localparam int unsigned DIV_W           = 24;
  localparam logic [CNT_W-1:0] BASE_TICKS = 12'(TIMEOUT_MIN_MS * 1000000 / RC_TICK_NS);

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] ADDR_FEED = 16'h00A6;
  localparam logic [15:0] ADDR_CTRL = 16'h00A7;
  localparam logic [15:0] ADDR_CFG1 = 16'hFD00;

  // ----------------------------------------------------------------
  // Fields and values
  // ----------------------------------------------------------------
  localparam int unsigned SEL_LSB    = 0;
  localparam int unsigned SEL_MSB    = 2;
  localparam int unsigned RUN_BIT    = 4;
  localparam int unsigned OVF_BIT    = 5;
  localparam int unsigned LOCK_BIT   = 6;
  localparam int unsigned EN_BIT     = 7;
  localparam int unsigned FUSE_EN_BIT = 7;
  localparam logic [2:0] SEL_RST     = 3'h7;
  localparam logic [7:0] FEED_FIRST  = 8'h1E;
  localparam logic [7:0] FEED_SECOND = 8'hE1;

  typedef enum logic [2:0] {
    WDIT_ST_RUN   = 3'b001,
    WDIT_ST_PULSE = 3'b010,
    WDIT_ST_WAIT  = 3'b100
  } wdit_state_t;

  function automatic logic [CNT_W-1:0] timeout_ticks(input logic [2:0] sel);
    timeout_ticks = BASE_TICKS << sel;
  endfunction

endpackage

// [hdl/wdit_rc_osc.sv]
// Free-running tick source standing in for the on-chip RC oscillator
`timescale 1ns/100ps
`default_nettype none
module wdit_rc_osc import wdit_pkg::*; #(
  parameter int unsigned DIV = RC_TICK_CYCLES
)(
  input  wire logic sys_clk,
  input  wire logic srst,
  output logic      tick
);

  logic [DIV_W-1:0] div_q;
  logic [DIV_W-1:0] div_d;
  logic             tick_q;
  logic             tick_d;

  generate
    if (DIV < 2 || DIV >= 2**DIV_W) begin : g_bad_div
      $error("wdit_rc_osc: DIV out of range");
    end
  endgenerate

  always_comb begin
    tick_d = (div_q == DIV_W'(DIV - 1));
    div_d  = tick_d ? '0 : div_q + DIV_W'(1);
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      div_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      div_q  <= div_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;

endmodule
`default_nettype wire

// [hdl/wdit_top.sv]
// Watchdog and interval timer with feed sequence and one-shot setup
//
// How it works
// - With the fuse set, software has no way to stop the counter.
// - Counter advances on ticks of its own oscillator, not the CPU clock.
// - Fuse clear: same counter is an interval timer raising an overflow interrupt.
// - Eight timeout choices, 16 ms up to 2.048 s.
// - Fuse set: only one control write is taken during initialization.
// - Expiry and reset still happen when the CPU oscillator has stopped.
// - Other reset sources hold the counter inactive while asserted.
// - A feed is 1Eh then E1h written to the feed register.
// - Other activity between the two feed writes does not spoil the feed.
// - A wrong feed is silently ignored; expiry stays where it was.
// - Expiry asserts chip reset for about one microsecond.
// - Expiry in power-down restarts the oscillator and waits until it is stable.
`timescale 1ns/100ps
`default_nettype none
module wdit_top import wdit_pkg::*; #(
  parameter int unsigned RC_TICK_CYC    = RC_TICK_CYCLES,
  parameter int unsigned OSC_STABLE_CYC = OSC_STABLE_CYCLES
)(
  input  wire logic        sys_clk,
  input  wire logic        srst,
  input  wire logic        other_rst,
  input  wire logic        power_down,
  input  wire logic [7:0]  config_fuse,
  input  wire logic [15:0] reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  output logic             chip_rst_o,
  output logic             osc_start_o,
  output logic             interval_irq
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  generate
    if (OSC_STABLE_CYC < 1 || OSC_STABLE_CYC >= 2**HOLD_W || RST_PULSE_CYCLES < 1) begin : g_bad
      $error("wdit_top: timing parameter out of range");
    end
  endgenerate

  // ----------------------------------------------------------------
  // Oscillator tick
  // ----------------------------------------------------------------
  logic osc_tick;

  wdit_rc_osc #(
    .DIV (RC_TICK_CYC)
  ) u_osc (
    .sys_clk (sys_clk),
    .srst    (srst),
    .tick    (osc_tick)
  );

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  wdit_state_t       state_q;
  wdit_state_t       state_d;
  logic [CNT_W-1:0]  cnt_q;
  logic [CNT_W-1:0]  cnt_d;
  logic [HOLD_W-1:0] hold_q;
  logic [HOLD_W-1:0] hold_d;
  logic [2:0]        sel_q;
  logic [2:0]        sel_d;
  logic              run_q;
  logic              run_d;
  logic              ovf_q;
  logic              ovf_d;
  logic              locked_q;
  logic              locked_d;
  logic              armed_q;
  logic              armed_d;
  logic [7:0]        fuse_q;
  logic [7:0]        fuse_d;
  logic [7:0]        rdata_q;
  logic [7:0]        rdata_d;

  logic              fuse_en;
  logic              bus_ok;
  logic              wr_ctrl;
  logic              wr_feed;
  logic              feed_ok;
  logic              counting;
  logic              expire;
  logic              end_reset;
  logic [CNT_W-1:0]  limit;

  assign fuse_en = fuse_q[FUSE_EN_BIT];

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    state_d  = state_q;
    cnt_d    = cnt_q;
    hold_d   = hold_q;
    sel_d    = sel_q;
    run_d    = run_q;
    ovf_d    = ovf_q;
    locked_d = locked_q;
    armed_d  = armed_q;
    fuse_d   = fuse_q;
    rdata_d  = rdata_q;

    bus_ok    = (state_q == WDIT_ST_RUN) && !other_rst;
    wr_ctrl   = bus_ok && reg_wr && (reg_addr == ADDR_CTRL);
    wr_feed   = bus_ok && reg_wr && (reg_addr == ADDR_FEED);
    feed_ok   = wr_feed && armed_q && (reg_wdata == FEED_SECOND);
    counting  = fuse_en || run_q;
    limit     = timeout_ticks(sel_q);
    expire    = (state_q == WDIT_ST_RUN) && counting && osc_tick
                && !feed_ok && (cnt_q == limit - CNT_W'(1));
    end_reset = 1'b0;

    // Feed sequencer; any other value drops the first half
    if (wr_feed) begin
      armed_d = (reg_wdata == FEED_FIRST);
    end

    // Control write, one shot when the fuse is set
    if (wr_ctrl && !(fuse_en && locked_q)) begin
      sel_d = reg_wdata[SEL_MSB:SEL_LSB];
      run_d = reg_wdata[RUN_BIT];
      if (fuse_en) begin
        locked_d = 1'b1;
      end
      if (!reg_wdata[OVF_BIT]) begin
        ovf_d = 1'b0;
      end
    end

    // Counter; no oscillator on the CPU side is involved
    if (feed_ok) begin
      cnt_d = '0;
    end else if (expire) begin
      cnt_d = '0;
    end else if (state_q == WDIT_ST_RUN && counting && osc_tick) begin
      cnt_d = cnt_q + CNT_W'(1);
    end

    unique case (state_q)
      WDIT_ST_RUN: begin
        if (expire) begin
          if (fuse_en) begin
            hold_d  = '0;
            state_d = power_down ? WDIT_ST_WAIT : WDIT_ST_PULSE;
          end else begin
            ovf_d = 1'b1;
          end
        end
      end
      WDIT_ST_PULSE: begin
        hold_d = hold_q + HOLD_W'(1);
        if (hold_q == HOLD_W'(RST_PULSE_CYCLES - 1)) begin
          end_reset = 1'b1;
        end
      end
      WDIT_ST_WAIT: begin
        hold_d = hold_q + HOLD_W'(1);
        if (hold_q == HOLD_W'(OSC_STABLE_CYC - 1)) begin
          end_reset = 1'b1;
        end
      end
    endcase

    // Leaving the watchdog reset clears state as a chip reset does, but only other_rst reloads the fuse copy
    if (end_reset || other_rst) begin
      state_d  = WDIT_ST_RUN;
      hold_d   = '0;
      cnt_d    = '0;
      sel_d    = SEL_RST;
      run_d    = 1'b0;
      ovf_d    = 1'b0;
      locked_d = 1'b0;
      armed_d  = 1'b0;
    end
    if (other_rst) begin
      fuse_d = config_fuse;
    end

    // Register read, one cycle latency
    if (reg_rd) begin
      unique case (reg_addr)
        ADDR_CTRL: rdata_d = {fuse_en, locked_q, ovf_q, run_q, 1'b0, sel_q};
        ADDR_CFG1: rdata_d = fuse_q;
        default:   rdata_d = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_q  <= WDIT_ST_RUN;
      cnt_q    <= '0;
      hold_q   <= '0;
      sel_q    <= SEL_RST;
      run_q    <= 1'b0;
      ovf_q    <= 1'b0;
      locked_q <= 1'b0;
      armed_q  <= 1'b0;
      fuse_q   <= config_fuse;
      rdata_q  <= 8'h00;
    end else begin
      state_q  <= state_d;
      cnt_q    <= cnt_d;
      hold_q   <= hold_d;
      sel_q    <= sel_d;
      run_q    <= run_d;
      ovf_q    <= ovf_d;
      locked_q <= locked_d;
      armed_q  <= armed_d;
      fuse_q   <= fuse_d;
      rdata_q  <= rdata_d;
    end
  end

  assign reg_rdata    = rdata_q;
  assign chip_rst_o   = (state_q != WDIT_ST_RUN);
  assign osc_start_o  = (state_q == WDIT_ST_WAIT);
  assign interval_irq = ovf_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_no_stop;
    @(posedge sys_clk) disable iff (srst)
    (fuse_en && state_q == WDIT_ST_RUN && osc_tick && !feed_ok && !expire && !other_rst)
      |=> (cnt_q == $past(cnt_q) + CNT_W'(1));
  endproperty
  a_no_stop: assert property (p_no_stop)
    else $error("enabled watchdog counter did not advance");

  property p_expire_point;
    @(posedge sys_clk) disable iff (srst)
    expire |-> (cnt_q == timeout_ticks(sel_q) - CNT_W'(1)) && osc_tick;
  endproperty
  a_expire_point: assert property (p_expire_point)
    else $error("expiry at wrong count");

  property p_lock;
    @(posedge sys_clk) disable iff (srst || other_rst)
    (fuse_en && locked_q && wr_ctrl) |=> (sel_q == $past(sel_q)) && (run_q == $past(run_q));
  endproperty
  a_lock: assert property (p_lock)
    else $error("locked control register changed");

  property p_first_write;
    @(posedge sys_clk) disable iff (srst || other_rst)
    (fuse_en && !locked_q && wr_ctrl) |=> locked_q && (sel_q == $past(reg_wdata[2:0]));
  endproperty
  a_first_write: assert property (p_first_write)
    else $error("first control write not taken");

  property p_other_rst;
    @(posedge sys_clk) disable iff (srst)
    other_rst |=> (cnt_q == '0) && !chip_rst_o;
  endproperty
  a_other_rst: assert property (p_other_rst)
    else $error("counter not held during other reset");

  property p_bad_feed;
    @(posedge sys_clk) disable iff (srst || other_rst)
    (wr_feed && !feed_ok && reg_wdata != FEED_FIRST && state_q == WDIT_ST_RUN)
      |=> !armed_q && (state_q != WDIT_ST_RUN || cnt_q != '0 || $past(expire) || $past(cnt_q) == '0
           || $past(!counting));
  endproperty
  a_bad_feed: assert property (p_bad_feed)
    else $error("wrong feed value had an effect");

  property p_feed_restart;
    @(posedge sys_clk) disable iff (srst || other_rst)
    feed_ok |=> (cnt_q == '0) && !armed_q;
  endproperty
  a_feed_restart: assert property (p_feed_restart)
    else $error("feed did not restart count");

  property p_pulse;
    @(posedge sys_clk) disable iff (srst || other_rst)
    (expire && fuse_en && !power_down) |=> chip_rst_o [*8];
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("watchdog reset pulse too short");

  property p_pd_wait;
    @(posedge sys_clk) disable iff (srst || other_rst)
    (expire && fuse_en && power_down) |=> (osc_start_o && chip_rst_o) [*8];
  endproperty
  a_pd_wait: assert property (p_pd_wait)
    else $error("power-down expiry did not wait for oscillator");

  property p_interval;
    @(posedge sys_clk) disable iff (srst || other_rst)
    (expire && !fuse_en) |=> interval_irq && !chip_rst_o;
  endproperty
  a_interval: assert property (p_interval)
    else $error("interval overflow handled wrongly");

endmodule
`default_nettype wire

// [dv/wdit_top_test.sv]
// Self-checking bench for the watchdog / interval timer
`timescale 1ns/100ps
`default_nettype none
module wdit_top_test;
  import wdit_pkg::*;
  localparam int TICK = 4;
  localparam int STAB = 20;
  logic        sys_clk;
  logic        srst;
  logic        other_rst;
  logic        power_down;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  config_fuse;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata;
  logic [15:0] reg_addr;
  logic        chip_rst_o;
  logic        osc_start_o;
  logic        interval_irq;
  logic [7:0]  v;
  logic [7:0]  fuse;
  int          n_errors;
  int          total_checks;
  int          n;
  int          t0;
  int          cyc = 0;
  int          m_sel;
  int          m_run;
  int          m_ovf;
  int          m_lock;
  int          m_en;

  wdit_top #(.RC_TICK_CYC(TICK), .OSC_STABLE_CYC(STAB)) i_dut (
    .sys_clk(sys_clk), .srst(srst), .other_rst(other_rst), .power_down(power_down),
    .config_fuse(config_fuse), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .chip_rst_o(chip_rst_o),
    .osc_start_o(osc_start_o), .interval_irq(interval_irq));

  // ----------------------------------------------------------------
  // Compare and bus tasks
  // ----------------------------------------------------------------
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_rng(input int got, input int lo, input int hi);
    total_checks++;
    if (got < lo || got > hi) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask

  // Control register model, kept from the rules
  function automatic logic [7:0] m_ctrl();
    return 8'((m_en << 7) | (m_lock << 6) | (m_ovf << 5) | (m_run << 4) | m_sel);
  endfunction

  task automatic m_reset();
    m_sel = 7;
    m_run = 0;
    m_ovf = 0;
    m_lock = 0;
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk) #2;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge sys_clk) #2;
    reg_wr = 1'b0;
    if (a == ADDR_CTRL && !(m_en != 0 && m_lock != 0)) begin
      m_sel = int'(d[2:0]);
      m_run = int'(d[4]);
      m_ovf = d[5] ? m_ovf : 0;
      m_lock = m_en;
    end
  endtask

  task automatic rdchk(input logic [15:0] a, input logic [7:0] e);
    @(posedge sys_clk) #2;
    reg_rd = 1'b1;
    reg_addr = a;
    @(posedge sys_clk) #2;
    reg_rd = 1'b0;
    check8(reg_rdata, e);
    if (a == ADDR_CTRL) check8(reg_rdata, m_ctrl());
  endtask

  task automatic feed();
    wr(ADDR_FEED, FEED_FIRST);
    wr(ADDR_FEED, FEED_SECOND);
  endtask

  // Cycles from t0 until the watchdog reset appears
  task automatic until_rst(output int c);
    while (chip_rst_o !== 1'b1 && cyc - t0 < 20000) @(posedge sys_clk) #2;
    c = cyc - t0;
  endtask

  task automatic high_len(output int c);
    c = 0;
    while (chip_rst_o === 1'b1 && c < 5000) begin
      @(posedge sys_clk) #2;
      c++;
    end
  endtask

  task automatic give_verdict();
    $display("Checks %0d, errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Clock, cycle count, watchdog
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) cyc <= cyc + 1;

  initial begin
    #800000;
    n_errors++;
    give_verdict();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(7590));
    fuse = 8'h80 | 8'($urandom() & 32'h7F);
    m_en = 1;
    m_reset();
    srst = 1'b1;
    other_rst = 1'b0;
    power_down = 1'b0;
    config_fuse = fuse;
    reg_addr = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
    n_errors = 0;
    total_checks = 0;
    repeat (20) @(posedge sys_clk);
    #2 srst = 1'b0;
    rdchk(ADDR_CTRL, 8'h87);
    rdchk(ADDR_CFG1, fuse);
    rdchk(ADDR_FEED, 8'h00);
    rdchk(16'h1234, 8'h00);
    // Every timeout code, each ended by its own watchdog reset
    for (int s = 0; s < 8; s++) begin
      feed();
      t0 = cyc;
      wr(ADDR_CTRL, 8'(s));
      rdchk(ADDR_CTRL, 8'hC0 | 8'(s));
      wr(ADDR_CTRL, 8'(7 - s));
      rdchk(ADDR_CTRL, 8'hC0 | 8'(s));
      until_rst(n);
      check_rng(n, (16 << s) * TICK - 6, (16 << s) * TICK + 6);
      high_len(n);
      check_rng(n, 50, 50);
      m_reset();
      rdchk(ADDR_CTRL, 8'h87);
    end
    // Broken feed keeps the old deadline
    feed();
    t0 = cyc;
    wr(ADDR_CTRL, 8'h00);
    repeat (20) @(posedge sys_clk);
    #2;
    v = 8'h20 | 8'($urandom() & 32'h0F);
    wr(ADDR_FEED, FEED_FIRST);
    wr(ADDR_FEED, v);
    wr(ADDR_FEED, FEED_SECOND);
    until_rst(n);
    check_rng(n, 58, 70);
    high_len(n);
    m_reset();
    // Feed split by other accesses restarts the full period
    feed();
    wr(ADDR_CTRL, 8'h00);
    repeat (30) @(posedge sys_clk);
    #2;
    wr(ADDR_FEED, FEED_FIRST);
    wr(ADDR_CTRL, v);
    rdchk(ADDR_CTRL, 8'hC0);
    wr(ADDR_FEED, FEED_SECOND);
    t0 = cyc;
    until_rst(n);
    check_rng(n, 58, 70);
    high_len(n);
    m_reset();
    // Expiry during power-down waits for the oscillator
    feed();
    t0 = cyc;
    wr(ADDR_CTRL, 8'h00);
    power_down = 1'b1;
    until_rst(n);
    check8({7'h00, osc_start_o}, 8'h01);
    high_len(n);
    check_rng(n, STAB, STAB);
    m_reset();
    power_down = 1'b0;
    // Outside reset holds the counter
    feed();
    wr(ADDR_CTRL, 8'h00);
    other_rst = 1'b1;
    config_fuse = fuse & 8'h7F;
    n = 0;
    repeat (200) begin
      @(posedge sys_clk) #2;
      n += int'(chip_rst_o === 1'b1);
    end
    check_rng(n, 0, 0);
    other_rst = 1'b0;
    m_en = 0;
    m_reset();
    rdchk(ADDR_CFG1, fuse & 8'h7F);
    rdchk(ADDR_CTRL, 8'h07);
    // Interval mode: overflow flag, clear, no lock
    wr(ADDR_CTRL, 8'h10);
    t0 = cyc;
    while (interval_irq !== 1'b1 && cyc - t0 < 300) @(posedge sys_clk) #2;
    check_rng(cyc - t0, 58, 70);
    m_ovf = 1;
    check8({7'h00, chip_rst_o}, 8'h00);
    rdchk(ADDR_CTRL, 8'h30);
    wr(ADDR_CTRL, 8'h03);
    check8({7'h00, interval_irq}, 8'h00);
    rdchk(ADDR_CTRL, 8'h03);
    give_verdict();
  end
endmodule
`default_nettype wire
